// *** ctr_map.svh ***
// constants for the clock translator control register bank
// assumes inclusion by ctr_pkg, ctr_regs and ctr_host, bare name
`ifndef CTR_MAP_SVH
`define CTR_MAP_SVH
// ************************************************
// register offsets
// ************************************************
`define CTR_ADR_CFG      6'h00
`define CTR_ADR_RDSEL    6'h04
`define CTR_ADR_UPDATE   6'h05
`define CTR_ADR_RA_HI    6'h1F
`define CTR_ADR_RA_LO    6'h20
`define CTR_ADR_RA_PRE   6'h21
`define CTR_ADR_RB_HI    6'h23
`define CTR_ADR_RB_LO    6'h24
`define CTR_ADR_RB_PRE   6'h25
`define CTR_ADR_XO_HI    6'h27
`define CTR_ADR_XO_LO    6'h28
`define CTR_ADR_SWO      6'h29
`define CTR_ADR_DRV1     6'h32
`define CTR_ADR_DRV2     6'h34
// ************************************************
// reset values
// ************************************************
`define CTR_RST_RA_HI    8'h40
`define CTR_RST_RB_HI    8'h80
`define CTR_RST_XO_HI    8'h40
`define CTR_RST_DRV      8'hA8
`define CTR_RST_ZERO     8'h00
// ************************************************
// field positions and masks
// ************************************************
`define CTR_CFG_LSB      6
`define CTR_CFG_SRST     5
`define CTR_LO_EN        1
`define CTR_MASK_LO      8'hFE
`define CTR_MASK_PRE     8'hF0
`define CTR_MASK_SWO     8'hE0
`define CTR_MASK_DRV     8'hFD
// ************************************************
// instruction framing
// ************************************************
`define CTR_INSTR_BITS   16
`endif

// *** ctr_pkg.sv ***
// types for the clock translator control register bank
// assumes ctr_map.svh is reachable by bare name
`include "ctr_map.svh"
package ctr_pkg;
  // decoded divider settings for the core
  typedef struct packed {
    logic [13:0] ratio;
    logic        doubler;
    logic        div5;
  } ctr_ref_type;
  // output driver settings
  typedef struct packed {
    logic       strength;
    logic       power_down;
    logic [2:0] mode;
    logic       cmos_pol;
  } ctr_drv_type;
  // pin-programmed defaults
  typedef struct packed {
    ctr_ref_type first_reference;
    ctr_ref_type second_reference;
    logic [13:0] crystal_ratio;
    logic [2:0]  first_mode;
    logic [2:0]  second_mode;
  } ctr_pins_type;
  // serial port states
  typedef enum logic [1:0] {
    CTR_IDLE,
    CTR_INSTR,
    CTR_WDATA,
    CTR_RDATA
  } ctr_state_type;
endpackage : ctr_pkg

// *** ctr_shifter.sv ***
// serial shift engine of the 3-wire port, one bit per strobe
// assumes sclk edges arrive as one-cycle strobes synchronous to clk_sys
`timescale 1ns/1ns
`default_nettype none
module ctr_shifter (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // control
  input  wire logic       clear,
  input  wire logic       shift,
  input  wire logic       lsb_first,
  input  wire logic       din,
  // result
  output logic [15:0]     word
);
  // shift register, direction chosen by bit order
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      word <= 16'h0000;
    end else if (clear) begin
      word <= 16'h0000;
    end else if (shift) begin
      if (lsb_first) begin
        word <= {din, word[15:1]};
      end else begin
        word <= {word[14:0], din};
      end
    end
  end
endmodule : ctr_shifter
`default_nettype wire

// *** ctr_regs.sv ***
// control register bank with 3-wire serial port and update buffer
// assumes sclk/sdio/cs_n sampled synchronously to clk_sys, no metastability
`timescale 1ns/1ns
`default_nettype none
`include "ctr_map.svh"
module ctr_regs (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 arst_n,
  // serial port pins
  input  wire logic                 sclk,
  input  wire logic                 cs_n,
  input  wire logic                 sdio_in,
  output logic                      sdio_out,
  output logic                      sdio_oe,
  // pin-programmed configuration
  input  wire ctr_pkg::ctr_pins_type pins,
  // settings toward the core
  output ctr_pkg::ctr_ref_type      first_reference,
  output ctr_pkg::ctr_ref_type      second_reference,
  output logic [13:0]               crystal_ratio,
  output logic [2:0]                switchover_mode,
  output logic                      differential_ref_select,
  output ctr_pkg::ctr_drv_type      first_clock_output,
  output ctr_pkg::ctr_drv_type      second_clock_output
);
  import ctr_pkg::*;

  // ************************************************
  // serial framing
  // ************************************************
  ctr_state_type state;
  logic          sclk_q;
  logic [3:0]    bit_cnt;
  logic [15:0]   word;
  logic          rise;
  logic          fall;
  logic          lsb_first;
  logic          read_op;
  logic [5:0]    addr;
  logic [7:0]    rd_shift;
  logic          wr_stb;
  logic [7:0]    wr_data;
  logic          soft_rst;
  logic          upd_stb;

  assign rise = sclk & ~sclk_q;
  assign fall = ~sclk & sclk_q;

  ctr_shifter u_shift (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .clear     (cs_n),
    .shift     (rise & ~cs_n & (state != CTR_RDATA)),
    .lsb_first (lsb_first),
    .din       (sdio_in),
    .word      (word)
  );

  // sclk history for edge detection
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
    end
  end

  // ************************************************
  // buffered and active register images
  // ************************************************
  logic [7:0] buf_r [0:10];
  logic [7:0] act_r [0:10];
  logic [7:0] cfg_hi;
  logic [7:0] cfg_rd;
  logic       rd_sel;

  // index into the buffered image, 4'hF when not buffered
  function automatic logic [3:0] slot(input logic [5:0] a);
    case (a)
      `CTR_ADR_RA_HI:  slot = 4'h0;
      `CTR_ADR_RA_LO:  slot = 4'h1;
      `CTR_ADR_RA_PRE: slot = 4'h2;
      `CTR_ADR_RB_HI:  slot = 4'h3;
      `CTR_ADR_RB_LO:  slot = 4'h4;
      `CTR_ADR_RB_PRE: slot = 4'h5;
      `CTR_ADR_XO_HI:  slot = 4'h6;
      `CTR_ADR_XO_LO:  slot = 4'h7;
      `CTR_ADR_SWO:    slot = 4'h8;
      `CTR_ADR_DRV1:   slot = 4'h9;
      `CTR_ADR_DRV2:   slot = 4'hA;
      default:         slot = 4'hF;
    endcase
  endfunction

  // writable mask per slot, unused bits stay zero
  function automatic logic [7:0] wmask(input logic [3:0] s);
    case (s)
      4'h1, 4'h4, 4'h7: wmask = `CTR_MASK_LO;
      4'h2, 4'h5:       wmask = `CTR_MASK_PRE;
      4'h8:             wmask = `CTR_MASK_SWO;
      4'h9, 4'hA:       wmask = `CTR_MASK_DRV;
      default:          wmask = 8'hFF;
    endcase
  endfunction

  // default value per slot
  function automatic logic [7:0] rstv(input logic [3:0] s);
    case (s)
      4'h0:       rstv = `CTR_RST_RA_HI;
      4'h3:       rstv = `CTR_RST_RB_HI;
      4'h6:       rstv = `CTR_RST_XO_HI;
      4'h9, 4'hA: rstv = `CTR_RST_DRV;
      default:    rstv = `CTR_RST_ZERO;
    endcase
  endfunction

  // full config byte: bit 7 zero, bit 4 one, low nibble mirror
  function automatic logic [7:0] cfg_byte(input logic [7:0] h);
    logic [3:0] n;
    n = {1'b0, h[6], h[5], 1'b1};
    cfg_byte = {n, n};
  endfunction

  assign lsb_first = cfg_hi[`CTR_CFG_LSB];
  assign cfg_rd    = cfg_byte(cfg_hi);
  assign soft_rst  = wr_stb & (addr == `CTR_ADR_CFG) &
                     wr_data[`CTR_CFG_SRST];
  assign upd_stb   = wr_stb & (addr == `CTR_ADR_UPDATE) & wr_data[0];

  // serial config and readback select; soft reset self clears
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfg_hi <= 8'h00;
      rd_sel <= 1'b0;
    end else if (soft_rst) begin
      cfg_hi <= 8'h00;
      rd_sel <= 1'b0;
    end else if (wr_stb && addr == `CTR_ADR_CFG) begin
      cfg_hi <= {1'b0, wr_data[6], 6'h00};
    end else if (wr_stb && addr == `CTR_ADR_RDSEL) begin
      rd_sel <= wr_data[0];
    end
  end

  // holding buffer takes serial writes
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 11; i++) buf_r[i] <= rstv(4'(i));
    end else if (soft_rst) begin
      for (int i = 0; i < 11; i++) buf_r[i] <= rstv(4'(i));
    end else if (wr_stb && slot(addr) != 4'hF) begin
      buf_r[slot(addr)] <= wr_data & wmask(slot(addr));
    end
  end

  // active image loads from the buffer only on update strobe
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 11; i++) act_r[i] <= rstv(4'(i));
    end else if (soft_rst) begin
      for (int i = 0; i < 11; i++) act_r[i] <= rstv(4'(i));
    end else if (upd_stb) begin
      for (int i = 0; i < 11; i++) act_r[i] <= buf_r[i];
    end
  end

  // read data mux; update bit is self clearing so reads zero
  function automatic logic [7:0] rd_val(input logic [5:0] a);
    logic [3:0] s;
    s = slot(a);
    if (a == `CTR_ADR_CFG) begin
      rd_val = cfg_byte(cfg_hi);
    end else if (a == `CTR_ADR_RDSEL) begin
      rd_val = {7'h00, rd_sel};
    end else if (s != 4'hF) begin
      rd_val = rd_sel ? buf_r[s] : act_r[s];
    end else begin
      rd_val = 8'h00;
    end
  endfunction

  // ************************************************
  // serial protocol engine
  // ************************************************
  // 16-bit instruction: r/w, two length bits ignored, 13-bit address of which only the low 6 bits are decoded
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state    <= CTR_IDLE;
      bit_cnt  <= 4'h0;
      read_op  <= 1'b0;
      addr     <= 6'h00;
      wr_stb   <= 1'b0;
      wr_data  <= 8'h00;
      rd_shift <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (cs_n) begin
        state   <= CTR_INSTR;
        bit_cnt <= 4'h0;
      end else begin
        case (state)
          CTR_IDLE: begin
            state <= CTR_INSTR;
          end
          CTR_INSTR: begin
            if (rise) begin
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == 4'hF) begin
                // lsb-first puts the r/w bit last
                read_op <= lsb_first ? sdio_in : word[14];
                addr    <= lsb_first ? word[6:1] : {word[4:0], sdio_in};
                if (lsb_first ? sdio_in : word[14]) begin
                  state    <= CTR_RDATA;
                  rd_shift <= rd_val(lsb_first ? word[6:1]
                                               : {word[4:0], sdio_in});
                end else begin
                  state <= CTR_WDATA;
                end
              end
            end
          end
          CTR_WDATA: begin
            if (rise) begin
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt[2:0] == 3'h7) begin
                wr_stb  <= 1'b1;
                wr_data <= lsb_first ? {sdio_in, word[15:9]}
                                     : {word[6:0], sdio_in};
              end
            end
            // streaming: next byte goes to addr + 1 in lsb-first order, addr - 1 in msb-first order
            if (wr_stb) begin
              addr <= lsb_first ? addr + 6'h1 : addr - 6'h1;
            end
          end
          CTR_RDATA: begin
            if (fall && bit_cnt != 4'h0) begin
              rd_shift <= lsb_first ? {1'b0, rd_shift[7:1]}
                                    : {rd_shift[6:0], 1'b0};
            end
            if (rise) begin
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt[2:0] == 3'h7) begin
                addr <= lsb_first ? addr + 6'h1 : addr - 6'h1;
              end
            end
            if (fall && bit_cnt[2:0] == 3'h0 && bit_cnt != 4'h0) begin
              rd_shift <= rd_val(addr);
            end
          end
          default: state <= CTR_IDLE;
        endcase
      end
    end
  end

  // drive the shared data pin only during a read data phase
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sdio_out <= 1'b0;
      sdio_oe  <= 1'b0;
    end else begin
      sdio_oe  <= ~cs_n & (state == CTR_RDATA);
      sdio_out <= lsb_first ? rd_shift[0] : rd_shift[7];
    end
  end

  // ************************************************
  // settings toward the core, register or pins
  // ************************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      first_reference  <= '0;
      second_reference <= '0;
      crystal_ratio    <= 14'h0000;
    end else begin
      first_reference.ratio <= act_r[1][`CTR_LO_EN] ?
        {act_r[0], act_r[1][7:2]} : pins.first_reference.ratio;
      second_reference.ratio <= act_r[4][`CTR_LO_EN] ?
        {act_r[3], act_r[4][7:2]} : pins.second_reference.ratio;
      crystal_ratio <= act_r[7][`CTR_LO_EN] ?
        {act_r[6], act_r[7][7:2]} : pins.crystal_ratio;
      first_reference.doubler <= act_r[2][7] ? act_r[2][6]
                               : pins.first_reference.doubler;
      first_reference.div5 <= act_r[2][5] ? act_r[2][4]
                            : pins.first_reference.div5;
      second_reference.doubler <= act_r[5][7] ? act_r[5][6]
                                : pins.second_reference.doubler;
      second_reference.div5 <= act_r[5][5] ? act_r[5][4]
                             : pins.second_reference.div5;
    end
  end

  // switchover and driver outputs
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      switchover_mode         <= 3'h0;
      differential_ref_select <= 1'b0;
      first_clock_output      <= '0;
      second_clock_output     <= '0;
    end else begin
      switchover_mode         <= {1'b0, act_r[8][7:6]};
      differential_ref_select <= act_r[8][5];
      first_clock_output  <= {act_r[9][7], act_r[9][6],
        act_r[9][0] ? act_r[9][5:3] : pins.first_mode,
        act_r[9][2]};
      second_clock_output <= {act_r[10][7], act_r[10][6],
        act_r[10][0] ? act_r[10][5:3] : pins.second_mode,
        act_r[10][2]};
    end
  end

  // ************************************************
  // checks
  // ************************************************
  property p_update_copies;
    @(posedge clk_sys) disable iff (!arst_n)
    upd_stb && !soft_rst |=> act_r[0] == $past(buf_r[0]);
  endproperty
  a_update_copies: assert property (p_update_copies)
    else $error("update strobe did not copy buffer");

  property p_hold_without_update;
    @(posedge clk_sys) disable iff (!arst_n)
    !upd_stb && !soft_rst |=> $stable(act_r[9]);
  endproperty
  a_hold_without_update: assert property (p_hold_without_update)
    else $error("active register changed without update");

  property p_cfg_fixed;
    @(posedge clk_sys) disable iff (!arst_n)
    cfg_rd[7] == 1'b0 && cfg_rd[4] == 1'b1;
  endproperty
  a_cfg_fixed: assert property (p_cfg_fixed)
    else $error("config fixed bits wrong");

  property p_mirror;
    @(posedge clk_sys) disable iff (!arst_n)
    cfg_rd[3:0] == cfg_rd[7:4];
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("config low nibble not mirrored");

  property p_soft_reset;
    @(posedge clk_sys) disable iff (!arst_n)
    soft_rst |=> act_r[9] == `CTR_RST_DRV && act_r[0] == `CTR_RST_RA_HI
                 && cfg_hi == 8'h00;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset did not restore defaults");

  property p_readback_sel;
    @(posedge clk_sys) disable iff (!arst_n)
    rd_sel |-> rd_val(`CTR_ADR_DRV1) == buf_r[9];
  endproperty
  a_readback_sel: assert property (p_readback_sel)
    else $error("readback did not return buffer");

  property p_unused_zero;
    @(posedge clk_sys) disable iff (!arst_n)
    rd_val(6'h22) == 8'h00 && buf_r[1][0] == 1'b0;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused bits not zero");

  property p_pin_source;
    @(posedge clk_sys) disable iff (!arst_n)
    !act_r[9][0] ##1 !act_r[9][0] |-> first_clock_output.mode
                                      == $past(pins.first_mode);
  endproperty
  a_pin_source: assert property (p_pin_source)
    else $error("driver mode not taken from pins");
endmodule : ctr_regs
`default_nettype wire

// *** ctr_host.sv ***
// host model of the 3-wire serial port: drives sclk, cs_n and its sdio leg
// assumes the bench resolves the sdio line from both parties' drive
`timescale 1ns/1ns
`default_nettype none
`include "ctr_map.svh"
module ctr_host (
  // clock
  input  wire logic       clk_sys,
  // serial port pins
  output logic            sclk,
  output logic            cs_n,
  output logic            sdio_drv,
  input  wire logic       sdio_line,
  // read result, one-cycle strobe
  output logic            rd_valid,
  output logic [7:0]      rd_data
);
  // idle: clock parked low, no frame
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdio_drv = 1'b0;
    rd_valid = 1'b0;
    rd_data = 8'h00;
  end

  // one bit: data set with sclk low, line sampled as sclk rises
  // released line toggles so a stale level never passes as read data
  task automatic shift_bit(input logic drive, input logic b, output logic got);
    @(posedge clk_sys);
    sclk <= 1'b0;
    sdio_drv <= drive ? b : ~sdio_drv;
    repeat (4) @(posedge clk_sys);
    got = sdio_line;
    sclk <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask

  // ****************************************
  // one single-byte frame
  // ****************************************
  task automatic xfer(input logic rd, input logic [5:0] adr,
                      input logic [7:0] wd, input logic lsb);
    logic [15:0] instr;
    logic [7:0]  rb;
    logic        got;
    instr = {rd, 9'h000, adr};
    rb = 8'h00;
    @(posedge clk_sys);
    cs_n <= 1'b0;
    for (int i = 0; i < `CTR_INSTR_BITS; i++) begin
      shift_bit(1'b1, instr[lsb ? i : 15 - i], got);
    end
    for (int i = 0; i < 8; i++) begin
      shift_bit(!rd, wd[lsb ? i : 7 - i], got);
      rb[lsb ? i : 7 - i] = got;
    end
    @(posedge clk_sys);
    sclk <= 1'b0;
    repeat (2) @(posedge clk_sys);
    cs_n <= 1'b1;
    rd_data <= rb;
    rd_valid <= rd;
    @(posedge clk_sys);
    rd_valid <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule // ctr_host
`default_nettype wire

// *** test_clock_translator_control_regs.sv ***
// self-checking bench of the control register bank
// assumes ctr_pkg, ctr_regs and ctr_host are compiled before it
`timescale 1ns/1ns
`default_nettype none
module test_clock_translator_control_regs;
  import ctr_pkg::*;
  localparam int NB = 11;
  logic              clk_sys;
  logic              arst_n;
  logic              sclk;
  logic              cs_n;
  logic              sdio_in;
  logic              sdio_out;
  logic              sdio_oe;
  logic              host_d;
  logic              rd_valid;
  logic [7:0]        rd_data;
  ctr_pins_type      pins;
  ctr_ref_type       first_reference;
  ctr_ref_type       second_reference;
  logic [13:0]       crystal_ratio;
  logic [2:0]        switchover_mode;
  logic              differential_ref_select;
  ctr_drv_type       first_clock_output;
  ctr_drv_type       second_clock_output;
  logic [7:0]        exp_q [$];
  logic [31:0]       seed = 32'hA8A1;
  logic              lsb_mode = 1'b0;
  int                n_errors = 0;
  int                tests_run = 0;
  logic [63:0]       tmp;
  logic [7:0]        val [NB];
  // buffered registers: offset, readable mask, reset value
  logic [5:0] adr_t [NB] = '{6'h1F, 6'h20, 6'h21, 6'h23, 6'h24, 6'h25,
                             6'h27, 6'h28, 6'h29, 6'h32, 6'h34};
  logic [7:0] msk_t [NB] = '{8'hFF, 8'hFE, 8'hF0, 8'hFF, 8'hFE, 8'hF0,
                             8'hFF, 8'hFE, 8'hE0, 8'hFD, 8'hFD};
  logic [7:0] rst_t [NB] = '{8'h40, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00,
                             8'h40, 8'h00, 8'h00, 8'hA8, 8'hA8};

  // clock, 4 ns period
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // sdio wire: device leg wins while it drives
  assign sdio_in = sdio_oe ? sdio_out : host_d;

  ctr_regs u_dut (
    .clk_sys                (clk_sys),
    .arst_n                 (arst_n),
    .sclk                   (sclk),
    .cs_n                   (cs_n),
    .sdio_in                (sdio_in),
    .sdio_out               (sdio_out),
    .sdio_oe                (sdio_oe),
    .pins                   (pins),
    .first_reference        (first_reference),
    .second_reference       (second_reference),
    .crystal_ratio          (crystal_ratio),
    .switchover_mode        (switchover_mode),
    .differential_ref_select(differential_ref_select),
    .first_clock_output     (first_clock_output),
    .second_clock_output    (second_clock_output)
  );

  ctr_host u_host (
    .clk_sys  (clk_sys),
    .sclk     (sclk),
    .cs_n     (cs_n),
    .sdio_drv (host_d),
    .sdio_line(sdio_in),
    .rd_valid (rd_valid),
    .rd_data  (rd_data)
  );

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  // enable bits pick the register field, else the pin value
  function automatic ctr_ref_type exp_ref(logic [7:0] hi, logic [7:0] lo,
                                          logic [7:0] pre, ctr_ref_type p);
    exp_ref.ratio = lo[1] ? {hi, lo[7:2]} : p.ratio;
    exp_ref.doubler = pre[7] ? pre[6] : p.doubler;
    exp_ref.div5 = pre[5] ? pre[4] : p.div5;
  endfunction

  function automatic ctr_drv_type exp_drv(logic [7:0] v, logic [2:0] m);
    return {v[7], v[6], v[0] ? v[5:3] : m, v[2]};
  endfunction

  task automatic compare_byte(input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected read at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic compare_val(input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected output at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    u_host.xfer(1'b0, a, d, lsb_mode);
  endtask

  // the expected byte is noted before the frame starts
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.xfer(1'b1, a, 8'h00, lsb_mode);
  endtask

  task automatic check_outputs(input logic [7:0] r [NB]);
    repeat (4) @(posedge clk_sys);
    compare_val(exp_ref(r[0], r[1], r[2], pins.first_reference),
                first_reference);
    compare_val(exp_ref(r[3], r[4], r[5], pins.second_reference),
                second_reference);
    compare_val({2'b00, r[7][1] ? {r[6], r[7][7:2]} : pins.crystal_ratio},
                {2'b00, crystal_ratio});
    compare_val({13'h0000, r[8][7:6], r[8][5]},
                {12'h000, switchover_mode, differential_ref_select});
    compare_val({10'h000, exp_drv(r[9], pins.first_mode)},
                {10'h000, first_clock_output});
    compare_val({10'h000, exp_drv(r[10], pins.second_mode)},
                {10'h000, second_clock_output});
  endtask

  task automatic wrap_up();
    // a read that never came back is a failure too
    if (exp_q.size() != 0) n_errors++;
    $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // read monitor: oldest note against each returned byte
  always @(posedge clk_sys) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() > 0) compare_byte(exp_q.pop_front(), rd_data);
      else compare_byte(8'hXX, rd_data);
    end
  end

  // watchdog, well beyond the expected run length
  initial begin
    #300000;
    n_errors++;
    wrap_up();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    arst_n = 1'b0;
    pins = '0;
    repeat (6) @(posedge clk_sys);
    tmp = {rnd(), rnd()};
    pins <= tmp[51:0];
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // defaults after reset
    check_outputs(rst_t);
    rd(6'h00, 8'h11);
    for (int i = 0; i < NB; i++) rd(adr_t[i], rst_t[i]);
    rd(6'h04, 8'h00);
    rd(6'h22, 8'h00);
    rd(6'h33, 8'h00);
    $display("test reset done");
    // buffered writes, readback source, update strobe
    for (int i = 0; i < NB; i++) val[i] = 8'(rnd());
    val[1][1] = 1'b1;
    val[4][1] = 1'b0;
    val[7][1] = 1'b1;
    val[9][0] = 1'b1;
    for (int i = 0; i < NB; i++) wr(adr_t[i], val[i]);
    wr(6'h22, 8'hFF);
    check_outputs(rst_t);
    for (int i = 0; i < NB; i++) rd(adr_t[i], rst_t[i]);
    wr(6'h04, 8'h01);
    rd(6'h04, 8'h01);
    for (int i = 0; i < NB; i++) rd(adr_t[i], val[i] & msk_t[i]);
    rd(6'h22, 8'h00);
    wr(6'h05, 8'h01);
    check_outputs(val);
    rd(6'h05, 8'h00);
    wr(6'h04, 8'h00);
    for (int i = 0; i < NB; i++) rd(adr_t[i], val[i] & msk_t[i]);
    $display("test buffer done");
    // lsb-first order, then soft reset from that mode
    wr(6'h00, 8'hCC);
    lsb_mode = 1'b1;
    rd(6'h00, 8'h55);
    val[10] = 8'(rnd());
    wr(6'h34, val[10]);
    wr(6'h05, 8'h01);
    rd(6'h34, val[10] & 8'hFD);
    wr(6'h04, 8'h01);
    wr(6'h00, 8'h22);
    lsb_mode = 1'b0;
    rd(6'h00, 8'h11);
    rd(6'h04, 8'h00);
    rd(6'h34, 8'hA8);
    check_outputs(rst_t);
    $display("test order done");
    wrap_up();
  end
endmodule // test_clock_translator_control_regs
`default_nettype wire
